// ### rtl/crb_cpu_regs.sv
`timescale 1ns/100ps
// Overview of operation
// RQ1: Thirteen registers; data, address and frame base exist in two banks.
// RQ2: Bank-select flag 0 uses bank 0, 1 uses bank 1.
// RQ3: Data registers are 16 bits, readable and writable for any operation.
// RQ4: First two data registers split into independent upper and lower bytes.
// RQ5: Data two with zero, and three with one, form 32-bit pairs.
// RQ6: Address registers 16 bits; concatenated with register one as upper half.
// RQ7: Frame base register is 16 bits for frame-relative addressing.
// RQ8: Vector table base is 20 bits.
// RQ9: Program counter is 20 bits holding next instruction address.
// RQ10: Stack-select 0 picks interrupt stack pointer, 1 picks user pointer.
// RQ11: Hardware interrupt acknowledge or software interrupt 0..31 clears stack-select.
// RQ12: Static base register is 16 bits.
// RQ13: Flag register is 11 bits showing processor state.
// RQ14: Carry flag captures ALU carry, borrow or shifted-out bit.
// RQ15: Zero flag set when result is zero, else cleared.
// RQ16: Sign flag set when result negative, else cleared.
// RQ17: Overflow flag set on overflow, else cleared.
// RQ18: Software keeps the debug flag written as zero.
// RQ19: Maskable interrupts blocked while interrupt-enable is 0.
// RQ20: Interrupt acknowledge clears interrupt-enable.
// RQ21: Three-bit priority level; request accepted only above current level.
// RQ22: Reserved flag bit reads undefined; software writes zero.
module crb_cpu_regs
  import crb_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  crb_wr_t          wr,
  input  crb_alu_t         alu,
  input  crb_irq_t         irq,
  input  wire logic        pc_inc,
  input  wire logic [2:0]  pc_step,
  input  crb_sel_t         rd_sel,
  input  crb_wid_t         rd_wid,
  input  wire logic        req_maskable,
  input  wire logic [2:0]  req_level,
  output logic [31:0]      rd_data,
  output logic [19:0]      pc,
  output logic [15:0]      sp_active,
  output logic [10:0]      processor_flags,
  output logic             req_accept
);

  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  logic rst_s1_r;
  logic rst_n_r;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] bank_r [CRB_NBANK][7];   // see RQ1
  logic [15:0] static_base_reg_r;
  logic [15:0] user_stack_ptr_r;
  logic [15:0] irq_stack_ptr_r;
  logic [19:0] vector_table_base_r;
  logic [19:0] pc_r;
  logic [10:0] flags_r;
  logic [10:0] flags_nxt;

  wire logic bsel = flags_r[FLG_B];
  wire logic usel = flags_r[FLG_U];

  function automatic logic [15:0] merge16(input logic [15:0] old, input crb_wid_t w,
                                          input logic [15:0] d);
    case (w)
      WID_LO8: merge16 = {old[15:8], d[7:0]};   // see RQ4
      WID_HI8: merge16 = {d[7:0], old[7:0]};    // see RQ4
      default: merge16 = d;
    endcase
  endfunction

  function automatic logic [2:0] bidx(input crb_sel_t s);
    case (s)
      SEL_D0:  bidx = 3'h0;
      SEL_D1:  bidx = 3'h1;
      SEL_D2:  bidx = 3'h2;
      SEL_D3:  bidx = 3'h3;
      SEL_A0:  bidx = 3'h4;
      SEL_A1:  bidx = 3'h5;
      default: bidx = 3'h6;
    endcase
  endfunction

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire logic       wr_bank = wr.en && (wr.sel <= SEL_FB);
  wire logic [2:0] wr_idx  = bidx(wr.sel);
  wire logic       wr_pair = wr_bank && (wr.wid == WID_L32) && (wr_idx == 3'h0 || wr_idx == 3'h1 || wr_idx == 3'h4);
  wire logic [2:0] hi_idx  = (wr_idx == 3'h4) ? 3'h5 : (wr_idx + 3'h2);  // see RQ5, RQ6
  wire logic       byte_ok = (wr_idx <= 3'h1) || (wr.wid == WID_W16) || (wr.wid == WID_L32);
  wire logic       wr_sp   = wr.en && (wr.sel == SEL_SP);

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int b = 0; b < CRB_NBANK; b++) begin
        for (int i = 0; i < 7; i++) begin
          bank_r[b][i] <= CRB_RST16;
        end
      end
    end else if (wr_bank && byte_ok) begin
      bank_r[bsel][wr_idx] <= merge16(bank_r[bsel][wr_idx], wr.wid, wr.data[15:0]);  // see RQ2, RQ3
      if (wr_pair) begin
        bank_r[bsel][hi_idx] <= wr.data[31:16];  // see RQ5, RQ6
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      static_base_reg_r   <= CRB_RST16;
      user_stack_ptr_r    <= CRB_RST16;
      irq_stack_ptr_r     <= CRB_RST16;
      vector_table_base_r <= CRB_RST20;
    end else if (wr.en) begin
      if (wr.sel == SEL_SB) begin
        static_base_reg_r <= wr.data[15:0];  // see RQ12
      end
      if (wr.sel == SEL_USP || (wr_sp && usel)) begin
        user_stack_ptr_r <= wr.data[15:0];  // see RQ10
      end
      if (wr.sel == SEL_ISP || (wr_sp && !usel)) begin
        irq_stack_ptr_r <= wr.data[15:0];  // see RQ10
      end
      if (wr.sel == SEL_VTB) begin
        vector_table_base_r <= wr.data[19:0];  // see RQ8
      end
    end
  end

  // ----------------------------------------
  // Program counter
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pc_r <= CRB_RST20;
    end else if (wr.en && wr.sel == SEL_PC) begin
      pc_r <= wr.data[19:0];  // see RQ9
    end else if (pc_inc) begin
      pc_r <= pc_r + {17'h00000, pc_step};  // see RQ9
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  wire logic swi_clr_u = irq.ack && !irq.hw && (irq.swi_num <= SWI_U_MAX);

  always_comb begin
    flags_nxt = flags_r;
    if (wr.en && wr.sel == SEL_FLG) begin
      flags_nxt = wr.data[10:0];  // see RQ13, RQ18, RQ22
    end
    if (alu.en) begin
      flags_nxt[FLG_C] = alu.c;  // see RQ14
      flags_nxt[FLG_Z] = alu.z;  // see RQ15
      flags_nxt[FLG_S] = alu.s;  // see RQ16
      flags_nxt[FLG_O] = alu.o;  // see RQ17
    end
    if (irq.ack) begin
      flags_nxt[FLG_I] = 1'b0;  // see RQ20
    end
    if ((irq.ack && irq.hw) || swi_clr_u) begin
      flags_nxt[FLG_U] = 1'b0;  // see RQ11
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      flags_r <= CRB_RSTF;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire logic [2:0]  rd_idx  = bidx(rd_sel);
  wire logic [15:0] rd_lo   = bank_r[bsel][rd_idx];
  wire logic [2:0]  rd_hi   = (rd_idx == 3'h4) ? 3'h5 : (rd_idx + 3'h2);
  wire logic [15:0] rd_up   = (rd_idx <= 3'h1 || rd_idx == 3'h4) ? bank_r[bsel][rd_hi] : CRB_RST16;
  wire logic [15:0] sp_sel  = usel ? user_stack_ptr_r : irq_stack_ptr_r;  // see RQ10
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h00000000;
    if (rd_sel <= SEL_FB) begin
      if (rd_wid == WID_L32) begin
        rd_mux = {rd_up, rd_lo};  // see RQ5, RQ6
      end else if (rd_wid == WID_HI8) begin
        rd_mux = {24'h000000, rd_lo[15:8]};  // see RQ4
      end else if (rd_wid == WID_LO8) begin
        rd_mux = {24'h000000, rd_lo[7:0]};  // see RQ4
      end else begin
        rd_mux = {16'h0000, rd_lo};  // see RQ7
      end
    end else if (rd_sel == SEL_SB) begin
      rd_mux = {16'h0000, static_base_reg_r};
    end else if (rd_sel == SEL_SP) begin
      rd_mux = {16'h0000, sp_sel};
    end else if (rd_sel == SEL_USP) begin
      rd_mux = {16'h0000, user_stack_ptr_r};
    end else if (rd_sel == SEL_ISP) begin
      rd_mux = {16'h0000, irq_stack_ptr_r};
    end else if (rd_sel == SEL_VTB) begin
      rd_mux = {12'h000, vector_table_base_r};
    end else if (rd_sel == SEL_PC) begin
      rd_mux = {12'h000, pc_r};
    end else begin
      rd_mux = {21'h000000, flags_r};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rd_data <= 32'h00000000;
    end else begin
      rd_data <= rd_mux;
    end
  end

  // ----------------------------------------
  // Priority gate
  // ----------------------------------------
  wire logic [2:0] processor_priority_level = flags_r[FLG_IPL +: FLG_IPLW];
  assign req_accept = (req_level > processor_priority_level) && (!req_maskable || flags_r[FLG_I]);  // see RQ19, RQ21

  assign pc              = pc_r;
  assign sp_active       = sp_sel;
  assign processor_flags = flags_r;

endmodule

// ### rtl/crb_pkg.sv
package crb_pkg;

  // ----------------------------------------
  // Widths and counts
  // ----------------------------------------
  localparam int CRB_DW    = 16;
  localparam int CRB_AW    = 20;
  localparam int CRB_FLGW  = 11;
  localparam int CRB_NREG  = 13;
  localparam int CRB_NBANK = 2;

  // ----------------------------------------
  // Flag bit positions
  // ----------------------------------------
  localparam int FLG_C   = 0;
  localparam int FLG_D   = 1;
  localparam int FLG_Z   = 2;
  localparam int FLG_S   = 3;
  localparam int FLG_B   = 4;
  localparam int FLG_O   = 5;
  localparam int FLG_I   = 6;
  localparam int FLG_U   = 7;
  localparam int FLG_IPL = 8;
  localparam int FLG_IPLW = 3;

  // ----------------------------------------
  // Reset values and software-interrupt stack-select limit
  // ----------------------------------------
  localparam logic [15:0] CRB_RST16 = 16'h0000;
  localparam logic [19:0] CRB_RST20 = 20'h00000;
  localparam logic [10:0] CRB_RSTF  = 11'h000;
  localparam logic [5:0]  SWI_U_MAX = 6'h1F;

  // ----------------------------------------
  // Register and width selects
  // ----------------------------------------
  typedef enum logic [3:0] {
    SEL_D0, SEL_D1, SEL_D2, SEL_D3, SEL_A0, SEL_A1, SEL_FB,
    SEL_SB, SEL_SP, SEL_USP, SEL_ISP, SEL_VTB, SEL_PC, SEL_FLG
  } crb_sel_t;

  typedef enum logic [2:0] {
    WID_W16, WID_LO8, WID_HI8, WID_L32
  } crb_wid_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic     en;
    crb_sel_t sel;
    crb_wid_t wid;
    logic [31:0] data;
  } crb_wr_t;

  typedef struct packed {
    logic en;
    logic c;
    logic z;
    logic s;
    logic o;
  } crb_alu_t;

  typedef struct packed {
    logic       ack;
    logic       hw;
    logic [5:0] swi_num;
  } crb_irq_t;

endpackage

// ### sim/crb_cpu_regs_properties.sv
`timescale 1ns/100ps
module crb_cpu_regs_chk
  import crb_pkg::*;
(
  input wire logic  sys_clk,
  input wire logic  rstn,
  input crb_wr_t    wr,
  input crb_alu_t   alu,
  input crb_irq_t   irq,
  input wire logic  pc_inc,
  input wire logic [2:0]  pc_step,
  input wire logic  req_maskable,
  input wire logic [2:0]  req_level,
  input wire logic [19:0] pc,
  input wire logic [10:0] processor_flags,
  input wire logic  req_accept
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire logic [2:0] processor_priority_level = processor_flags[FLG_IPL+:FLG_IPLW];
  wire logic pc_wr = wr.en && wr.sel == SEL_PC;
  sequence s_ack;
    irq.ack;
  endsequence
  chk_alu_carry: assert property (alu.en |=> processor_flags[FLG_C] == $past(alu.c)) else $error("carry");
  chk_alu_zero: assert property (alu.en |=> processor_flags[FLG_Z] == $past(alu.z)) else $error("zero");
  chk_alu_sign: assert property (alu.en |=> processor_flags[FLG_S] == $past(alu.s)) else $error("sign");
  chk_alu_ovf: assert property (alu.en |=> processor_flags[FLG_O] == $past(alu.o)) else $error("ovf");
  chk_ack_irqen: assert property (s_ack |=> !processor_flags[FLG_I]) else $error("ie kept");
  chk_ack_stack: assert property (s_ack ##0 (irq.hw || irq.swi_num <= SWI_U_MAX) |=> !processor_flags[FLG_U])
    else $error("stack sel kept");
  chk_accept_level: assert property (req_accept |-> req_level > processor_priority_level) else $error("low level taken");
  chk_mask_block: assert property (req_maskable && !processor_flags[FLG_I] |-> !req_accept)
    else $error("masked taken");
  chk_accept_when: assert property (req_level > processor_priority_level && (!req_maskable || processor_flags[FLG_I]) |-> req_accept)
    else $error("refused");
  chk_pc_step: assert property (pc_inc && !pc_wr && !irq.ack |=> pc == $past(pc) + $past(pc_step))
    else $error("pc step");
  chk_pc_hold: assert property (!pc_inc && !pc_wr && !irq.ack |=> $stable(pc)) else $error("pc moved");
endmodule
bind crb_cpu_regs crb_cpu_regs_chk crb_cpu_regs_chk_i (.sys_clk(sys_clk), .rstn(rstn), .wr(wr), .alu(alu),
  .irq(irq), .pc_inc(pc_inc), .pc_step(pc_step), .req_maskable(req_maskable), .req_level(req_level), .pc(pc),
  .processor_flags(processor_flags), .req_accept(req_accept));

// ### sim/crb_dp_model.sv
`timescale 1ns/100ps
module crb_dp_model
  import crb_pkg::*;
(
  input wire logic  sys_clk,
  output crb_wr_t   wr,
  output crb_alu_t  alu,
  output crb_irq_t  irq,
  output logic      pc_inc,
  output logic [2:0] pc_step
);
  initial begin
    wr = '0;
    alu = '0;
    irq = '0;
    pc_inc = 1'b0;
    pc_step = 3'h0;
  end
  task automatic wreg(input crb_sel_t s, input crb_wid_t w, input logic [31:0] d);
    @(posedge sys_clk) #1 wr = '{1'b1, s, w, d};
    @(posedge sys_clk) #1 wr.en = 1'b0;
    wr.data = ~wr.data;
  endtask
  // Debug bit always written as zero
  task automatic wflg(input logic [10:0] f);
    wreg(SEL_FLG, WID_W16, {21'h0, f & 11'h7FD});
  endtask
  task automatic alu_op(input logic [3:0] k);
    @(posedge sys_clk) #1 alu = {1'b1, k};
    @(posedge sys_clk) #1 alu = {1'b0, ~k};
  endtask
  task automatic ack(input logic hw, input logic [5:0] n);
    @(posedge sys_clk) #1 irq = '{1'b1, hw, n};
    @(posedge sys_clk) #1 irq.ack = 1'b0;
  endtask
  task automatic step(input logic [2:0] n);
    @(posedge sys_clk) #1 pc_inc = 1'b1;
    pc_step = n;
    @(posedge sys_clk) #1 pc_inc = 1'b0;
    pc_step = ~n;
  endtask
endmodule

// ### sim/crb_cpu_regs_test.sv
`timescale 1ns/100ps
module crb_cpu_regs_test
  import crb_pkg::*;
;
  logic sys_clk = 0, rstn = 0, req_maskable = 0;
  logic [2:0] req_level = 0, pc_step;
  crb_sel_t rd_sel = SEL_D0;
  crb_wid_t rd_wid = WID_W16;
  crb_wr_t wr;
  crb_alu_t alu;
  crb_irq_t irq;
  logic pc_inc, req_accept;
  logic [31:0] rd_data;
  logic [19:0] pc;
  logic [15:0] sp_active;
  logic [10:0] processor_flags;
  int bad_count = 0, num_checks = 0;
  crb_cpu_regs crb_cpu_regs_i (.sys_clk(sys_clk), .rstn(rstn), .wr(wr), .alu(alu), .irq(irq), .pc_inc(pc_inc),
    .pc_step(pc_step), .rd_sel(rd_sel), .rd_wid(rd_wid), .req_maskable(req_maskable), .req_level(req_level),
    .rd_data(rd_data), .pc(pc), .sp_active(sp_active), .processor_flags(processor_flags), .req_accept(req_accept));
  crb_dp_model crb_dp_model_i (.sys_clk(sys_clk), .wr(wr), .alu(alu), .irq(irq), .pc_inc(pc_inc), .pc_step(pc_step));
  initial forever #25 sys_clk = ~sys_clk;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdchk(input crb_sel_t s, input crb_wid_t w, input logic [31:0] e);
    rd_sel = s;
    rd_wid = w;
    @(posedge sys_clk) #1 chk(rd_data, e);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d bad=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_banks;
    crb_dp_model_i.wreg(SEL_D0, WID_W16, 32'h1111);
    crb_dp_model_i.wflg(11'h1 << FLG_B);
    crb_dp_model_i.wreg(SEL_D0, WID_W16, 32'h2222);
    rdchk(SEL_D0, WID_W16, 32'h2222);
    crb_dp_model_i.wflg(11'h0);
    rdchk(SEL_D0, WID_W16, 32'h1111);
  endtask
  task automatic t_parts;
    crb_dp_model_i.wreg(SEL_D1, WID_W16, 32'hABCD);
    crb_dp_model_i.wreg(SEL_D1, WID_LO8, 32'h12);
    rdchk(SEL_D1, WID_W16, 32'hAB12);
    crb_dp_model_i.wreg(SEL_D1, WID_HI8, 32'h34);
    rdchk(SEL_D1, WID_W16, 32'h3412);
    rdchk(SEL_D1, WID_HI8, 32'h34);
    rdchk(SEL_D1, WID_LO8, 32'h12);
    crb_dp_model_i.wreg(SEL_D0, WID_L32, 32'h89ABCDEF);
    rdchk(SEL_D2, WID_W16, 32'h89AB);
    rdchk(SEL_D0, WID_L32, 32'h89ABCDEF);
    crb_dp_model_i.wreg(SEL_A0, WID_L32, 32'h13572468);
    rdchk(SEL_A1, WID_W16, 32'h1357);
    crb_dp_model_i.wreg(SEL_FB, WID_W16, 32'h1234FFFF);
    rdchk(SEL_FB, WID_W16, 32'hFFFF);
    crb_dp_model_i.wreg(SEL_SB, WID_W16, 32'h0000BEEF);
    rdchk(SEL_SB, WID_W16, 32'hBEEF);
    crb_dp_model_i.wreg(SEL_VTB, WID_W16, 32'h0000C0DE);
    rdchk(SEL_VTB, WID_W16, 32'hC0DE);
  endtask
  task automatic t_stack;
    crb_dp_model_i.wreg(SEL_ISP, WID_W16, 32'h5555);
    crb_dp_model_i.wflg((11'h1 << FLG_U) | (11'h1 << FLG_I));
    crb_dp_model_i.wreg(SEL_SP, WID_W16, 32'hAAAA);
    chk(sp_active, 32'hAAAA);
    rdchk(SEL_USP, WID_W16, 32'hAAAA);
    rdchk(SEL_ISP, WID_W16, 32'h5555);
    rdchk(SEL_SP, WID_W16, 32'hAAAA);
    crb_dp_model_i.ack(1'b0, 6'd32);
    chk(processor_flags, 11'h1 << FLG_U);
    rdchk(SEL_FLG, WID_W16, 32'h80);
    crb_dp_model_i.ack(1'b0, 6'd31);
    chk(sp_active, 32'h5555);
    crb_dp_model_i.wflg((11'h1 << FLG_U) | (11'h1 << FLG_I));
    crb_dp_model_i.ack(1'b1, 6'd40);
    chk(processor_flags, 32'h0);
  endtask
  task automatic t_alu;
    for (int k = 0; k < 16; k++) begin
      crb_dp_model_i.alu_op(k[3:0]);
      chk({processor_flags[FLG_C], processor_flags[FLG_Z], processor_flags[FLG_S], processor_flags[FLG_O]},
          k);
    end
  endtask
  task automatic t_accept;
    for (int i = 0; i < 8; i++) begin
      crb_dp_model_i.wflg((11'(i) << FLG_IPL) | (11'h1 << FLG_I));
      for (int l = 0; l < 8; l++) begin
        req_level = l[2:0];
        req_maskable = l[0];
        #1 chk(req_accept, l > i);
      end
    end
    crb_dp_model_i.wflg(11'h0);
    req_maskable = 1'b1;
    #1 chk(req_accept, 32'h0);
  endtask
  task automatic t_pc;
    crb_dp_model_i.step(3'd7);
    crb_dp_model_i.step(3'd5);
    chk(pc, 32'hC);
    rdchk(SEL_PC, WID_W16, 32'hC);
  endtask
  initial begin
    #500000 bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 chk(pc, 32'h0);
    chk(processor_flags, 32'h0);
    chk(sp_active, 32'h0);
    rstn = 1'b1;
    repeat (3) @(posedge sys_clk);
    t_banks();
    t_parts();
    t_stack();
    t_alu();
    t_accept();
    t_pc();
    report_and_stop();
  end
endmodule
